// File: swseq_top.v
// seam weld sequencer: initiation, schedule pick, heat/cool/hold sequencing
// Contract
// - seam mode nonzero enters seam operation; 00 returns to spot.
// - current starts and stops on line-cycle boundaries following initiation.
// - intermittent seam conducts in heat only, repeats heat-cool while initiated.
// - initiation opening in heat ends impulses at once, goes to hold.
// - initiation opening in cool finishes cool, then goes to hold.
// - cool time 00 gives continuous conduction while initiated.
// - highest closed initiation input selects the active schedule.
// - schedule changes take effect immediately within heat or cool.
// - first input uses panel schedule, second 10, third 20.
// - open temperature switch raises and shows temperature error code.
// - mode 02 lets data buttons raise or lower percent current while welding.
// - mode 03 second input jumps to spot sequence on schedule 10.
// - mode 03 allows a no-weld spot chain before the seam part.
// - mode x4 measures only for the first x weld cycles, then regulates.
// - holds a programmable identification number for up to 64 nodes.
// - all intervals count whole line cycles.
// - seam is beat operation; chaining unavailable in normal seam.
`include "swseq_consts.vh"

module swseq_top #(
	parameter SW = 6
) (
	input  wire          mclk,
	input  wire          sys_rst,
	input  wire          line_zero_cross,
	input  wire          initiate_input_primary,
	input  wire          initiate_input_second,
	input  wire          initiate_input_third,
	input  wire          temp_switch_closed,
	input  wire          btn_tens,
	input  wire          btn_units,
	input  wire [7:0]    seam_mode,
	input  wire [SW-1:0] panel_sched,
	input  wire [7:0]    squeeze_cyc,
	input  wire [7:0]    heat_cyc,
	input  wire [7:0]    cool_cyc,
	input  wire [7:0]    hold_cyc,
	input  wire [6:0]    pct_in,
	input  wire          pre_chain_en,
	input  wire          id_wr,
	input  wire [5:0]    id_in,
	output reg           fire_ff,
	output reg  [SW-1:0] sched_ff,
	output reg  [6:0]    pct_ff,
	output reg           regulate_ff,
	output reg  [7:0]    err_code_ff,
	output reg  [4:0]    state_ff,
	output reg           spot_req_ff,
	output reg  [5:0]    node_id_ff
);
	// one-hot sequence states
	localparam ST_IDLE = 5'h01;
	localparam ST_SQZ  = 5'h02;
	localparam ST_HEAT = 5'h04;
	localparam ST_COOL = 5'h08;
	localparam ST_HOLD = 5'h10;

	// number of pins that pass the shared synchroniser loop
	localparam NPIN = 7;
	// the temperature switch rests closed so reset raises no false error
	localparam [NPIN-1:0] PIN_RST = 7'h08;

	// raw pins, lowest bit first
	wire [NPIN-1:0] pin_raw;
	wire [NPIN-1:0] pin_q;
	assign pin_raw[0] = initiate_input_primary;
	assign pin_raw[1] = initiate_input_second;
	assign pin_raw[2] = initiate_input_third;
	assign pin_raw[3] = temp_switch_closed;
	assign pin_raw[4] = line_zero_cross;
	assign pin_raw[5] = btn_tens;
	assign pin_raw[6] = btn_units;

	// three-stage synchronisers; a level counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			reg [2:0] sh_ff;
			reg       q_ff;
			always @(posedge mclk) begin
				if (sys_rst) begin
					sh_ff <= {3{PIN_RST[gi]}};
					q_ff  <= PIN_RST[gi];
				end else begin
					sh_ff <= {sh_ff[1:0], pin_raw[gi]};
					if (sh_ff[2] == sh_ff[1])
						q_ff <= sh_ff[2]; // filtered level
				end
			end
			assign pin_q[gi] = q_ff;
		end
	endgenerate

	// filtered levels by name
	wire in1_q = pin_q[0];
	wire in2_q = pin_q[1];
	wire in3_q = pin_q[2];
	wire tmp_q = pin_q[3];
	wire zc_q  = pin_q[4];
	wire bt_q  = pin_q[5];
	wire bu_q  = pin_q[6];

	// line-cycle tick and button presses as one-clock pulses
	reg  zc_d_ff;
	reg  bt_d_ff;
	reg  bu_d_ff;
	wire tick    = zc_q & ~zc_d_ff;
	wire up_ev   = bt_q & ~bt_d_ff;
	wire dn_ev   = bu_q & ~bu_d_ff;

	// mode decode and initiation summary
	wire any_in  = in1_q | in2_q | in3_q;
	wire seam_on = (seam_mode != `SWSEQ_MODE_SPOT);
	wire combo   = (seam_mode == `SWSEQ_MODE_COMBO);
	wire adj     = (seam_mode == `SWSEQ_MODE_ADJ);
	wire dlymode = (seam_mode[3:0] == `SWSEQ_MODE_DLYLO);
	wire [3:0] dly_x = seam_mode[7:4];
	wire spot_run = ~seam_on | spot_req_ff;

	// schedule selection from the highest closed input
	reg [SW-1:0] nxt_sched;
	always @* begin
		if (in3_q)
			nxt_sched = `SWSEQ_SCHED_THIRD;
		else if (in2_q)
			nxt_sched = `SWSEQ_SCHED_SEC;
		else
			nxt_sched = panel_sched;
	end

	// edge-detector history
	always @(posedge mclk) begin
		if (sys_rst) begin
			zc_d_ff <= 1'b0;
			bt_d_ff <= 1'b0;
			bu_d_ff <= 1'b0;
		end else begin
			zc_d_ff <= zc_q;
			bt_d_ff <= bt_q;
			bu_d_ff <= bu_q;
		end
	end

	// sequencer state and counters
	reg [7:0] cnt_ff;
	reg [3:0] wcyc_ff;
	reg       armed_ff;
	reg       pre_ff;
	// weld cycles measured, counting the one now ending
	wire [4:0] wcyc_nx = {1'b0, wcyc_ff} + 5'h01;

	// percent current: follow the schedule, or step by buttons while welding
	always @(posedge mclk) begin
		if (sys_rst) begin
			pct_ff <= 7'h00;
		end else if (adj && state_ff == ST_HEAT) begin
			if (up_ev && pct_ff < `SWSEQ_PCT_MAX)
				pct_ff <= pct_ff + 7'h01;
			else if (dn_ev && pct_ff != 7'h00)
				pct_ff <= pct_ff - 7'h01;
		end else if (state_ff == ST_IDLE || !adj) begin
			pct_ff <= pct_in;
		end
	end

	// main sequencer
	always @(posedge mclk) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 8'h00;
			fire_ff <= 1'b0;
			sched_ff <= {SW{1'b0}};
			spot_req_ff <= 1'b0;
			armed_ff <= 1'b1;
			wcyc_ff <= 4'h0;
			regulate_ff <= 1'b0;
			pre_ff <= 1'b0;
		end else begin
			// all contacts open re-arms initiation
			if (!any_in)
				armed_ff <= 1'b1;
			// seam schedule follows the contacts inside heat and cool
			if (state_ff != ST_IDLE && seam_on && !spot_req_ff)
				sched_ff <= nxt_sched;
			// combination mode: second contact forces a spot sequence
			if (combo && in2_q && state_ff != ST_IDLE && !spot_req_ff) begin
				spot_req_ff <= 1'b1;
				sched_ff <= `SWSEQ_SCHED_SEC;
				state_ff <= ST_SQZ;
				cnt_ff <= 8'h00;
				fire_ff <= 1'b0;
			end else begin
				case (state_ff)
				// wait for a fresh closure at a line-cycle boundary
				ST_IDLE: begin
					fire_ff <= 1'b0;
					regulate_ff <= 1'b0;
					wcyc_ff <= 4'h0;
					spot_req_ff <= 1'b0;
					if (any_in && armed_ff && tick) begin
						armed_ff <= 1'b0;
						sched_ff <= nxt_sched;
						spot_req_ff <= ~seam_on | (combo & in2_q);
						pre_ff <= combo & pre_chain_en & in1_q;
						state_ff <= ST_SQZ;
						cnt_ff <= 8'h00;
					end
				end
				// squeeze, repeated once without weld for a pre-chain
				ST_SQZ: begin
					if (tick) begin
						if (cnt_ff + 8'h01 >= squeeze_cyc) begin
							cnt_ff <= 8'h00;
							if (pre_ff) begin
								pre_ff <= 1'b0;
							end else begin
								state_ff <= ST_HEAT;
								fire_ff <= 1'b1;
							end
						end else begin
							cnt_ff <= cnt_ff + 8'h01;
						end
					end
				end
				// heat: conduct; contacts opening in seam cut the impulse at once
				ST_HEAT: begin
					if (!spot_run && !any_in) begin
						fire_ff <= 1'b0;
						state_ff <= ST_HOLD;
						cnt_ff <= 8'h00;
					end else if (tick) begin
						if (dlymode && wcyc_nx >= {1'b0, dly_x})
							regulate_ff <= 1'b1;
						if (wcyc_ff != 4'hF)
							wcyc_ff <= wcyc_ff + 4'h1;
						if (!spot_run && cool_cyc == 8'h00) begin
							cnt_ff <= 8'h00;
						end else if (cnt_ff + 8'h01 >= heat_cyc) begin
							cnt_ff <= 8'h00;
							fire_ff <= 1'b0;
							state_ff <= spot_run ? ST_HOLD : ST_COOL;
						end else begin
							cnt_ff <= cnt_ff + 8'h01;
						end
					end
				end
				// cool runs out unless the mode 03 second contact jumps to spot, then heat again or hold
				ST_COOL: begin
					if (tick) begin
						if (cnt_ff + 8'h01 >= cool_cyc) begin
							cnt_ff <= 8'h00;
							if (any_in) begin
								state_ff <= ST_HEAT;
								fire_ff <= 1'b1;
							end else begin
								state_ff <= ST_HOLD;
							end
						end else begin
							cnt_ff <= cnt_ff + 8'h01;
						end
					end
				end
				// hold: no conduction, then back to idle
				ST_HOLD: begin
					fire_ff <= 1'b0;
					if (tick) begin
						if (cnt_ff + 8'h01 >= hold_cyc) begin
							state_ff <= ST_IDLE;
							cnt_ff <= 8'h00;
						end else begin
							cnt_ff <= cnt_ff + 8'h01;
						end
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					fire_ff <= 1'b0;
				end
				endcase
			end
		end
	end

	// temperature error follows the filtered switch level
	always @(posedge mclk) begin
		if (sys_rst) begin
			err_code_ff <= 8'h00;
		end else begin
			err_code_ff <= tmp_q ? 8'h00 : `SWSEQ_ERR_TEMP;
		end
	end

	// node identity, loaded by a write strobe
	always @(posedge mclk) begin
		if (sys_rst) begin
			node_id_ff <= `SWSEQ_ID_RST;
		end else if (id_wr) begin
			node_id_ff <= id_in;
		end
	end
endmodule

// File: swseq_consts.vh
// constants for the seam weld sequencer
`ifndef SWSEQ_CONSTS_VH
`define SWSEQ_CONSTS_VH
`define SWSEQ_MODE_SPOT   8'h00
`define SWSEQ_MODE_SEAM   8'h01
`define SWSEQ_MODE_ADJ    8'h02
`define SWSEQ_MODE_COMBO  8'h03
`define SWSEQ_MODE_DLYLO  4'h4
`define SWSEQ_SCHED_SEC   6'h0A
`define SWSEQ_SCHED_THIRD 6'h14
`define SWSEQ_ERR_TEMP    8'h01
`define SWSEQ_PCT_MAX     7'h63
`define SWSEQ_ID_RST      6'h00
`endif

// File: swseq_asserts.sv
// port checker for the seam weld sequencer
module swseq_chk #(parameter SW = 6) (
	input logic          mclk,
	input logic          sys_rst,
	input logic          initiate_input_primary,
	input logic          initiate_input_second,
	input logic          initiate_input_third,
	input logic          temp_switch_closed,
	input logic          id_wr,
	input logic [5:0]    id_in,
	input logic          fire_ff,
	input logic [SW-1:0] sched_ff,
	input logic [7:0]    err_code_ff,
	input logic [4:0]    state_ff,
	input logic [5:0]    node_id_ff,
	input logic          spot_req_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// all contacts open
	wire all_open = !initiate_input_primary && !initiate_input_second && !initiate_input_third;
	a_err_open: assert property (!temp_switch_closed [*6] |=> err_code_ff == 8'h01)
		else $error("no error code with switch open");
	a_err_clear: assert property (temp_switch_closed [*6] |=> err_code_ff == 8'h00)
		else $error("error code with switch closed");
	a_fire_heat: assert property (fire_ff |-> state_ff == 5'h04)
		else $error("firing outside heat");
	a_idle_exit: assert property ($past(state_ff) == 5'h01 && state_ff != 5'h01 |-> state_ff == 5'h02)
		else $error("idle not left to squeeze");
	a_hold_exit: assert property ($past(state_ff) == 5'h10 && state_ff != 5'h10 |-> state_ff == 5'h01)
		else $error("hold not left to idle");
	a_heat_open: assert property ((state_ff == 5'h04 && all_open && !spot_req_ff) [*6] |=> state_ff == 5'h10)
		else $error("heat kept after opening");
	a_sched_third: assert property ((initiate_input_third && fire_ff && !spot_req_ff) [*6] |=> sched_ff == 20)
		else $error("third contact schedule wrong");
	a_id_load: assert property (id_wr |=> node_id_ff == $past(id_in))
		else $error("node id not loaded");
	c_cool: cover property (state_ff == 5'h08);
	c_hold: cover property ($past(state_ff) == 5'h04 && state_ff == 5'h10);
	c_sched: cover property (sched_ff == 20 && fire_ff);
endmodule

bind swseq_top swseq_chk #(.SW(SW)) u_chk (.mclk, .sys_rst, .initiate_input_primary,
	.initiate_input_second, .initiate_input_third, .temp_switch_closed, .id_wr, .id_in,
	.fire_ff, .sched_ff, .err_code_ff, .state_ff, .node_id_ff, .spot_req_ff);

// File: swseq_switch.sv
// initiation contact model
module swseq_switch (
	input  wire  [2:0] want,
	input  wire        mclk,
	output logic [2:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// dry contacts move on the falling edge, open unless asked
	initial pins = 3'h0;
	always @(negedge mclk) pins <= want;
endmodule

// File: swseq_top_tb.sv
// self-checking bench for the seam weld sequencer
module swseq_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk, sys_rst, line_zero_cross, temp_switch_closed, id_wr, fire_ff;
	logic [7:0] seam_mode, heat_cyc, cool_cyc, err_code_ff;
	logic [5:0] id_in, sched_ff, node_id_ff;
	logic [4:0] state_ff, tcnt;
	logic [2:0] want;
	logic       btn_tens, btn_units, pre_chain_en, regulate_ff, spot_req_ff;
	logic [6:0] pct_ff;
	wire  [2:0] pins;
	int         errors, compares;
	swseq_switch i_sw (.want, .mclk, .pins);
	swseq_top i_dut (.mclk, .sys_rst, .line_zero_cross, .initiate_input_primary(pins[0]),
		.initiate_input_second(pins[1]), .initiate_input_third(pins[2]), .temp_switch_closed,
		.btn_tens, .btn_units, .seam_mode, .panel_sched(6'h05), .squeeze_cyc(heat_cyc),
		.heat_cyc, .cool_cyc, .hold_cyc(heat_cyc), .pct_in(7'h32), .pre_chain_en, .id_wr,
		.id_in, .fire_ff, .sched_ff, .pct_ff, .regulate_ff, .err_code_ff, .state_ff,
		.spot_req_ff, .node_id_ff);
	initial begin
		mclk = 0;
		forever #20 mclk = ~mclk;
	end
	// shortened line tick, one every 32 clocks
	always @(negedge mclk) begin
		tcnt <= tcnt + 5'h01;
		line_zero_cross <= tcnt[4:2] == 3'h0;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait for a state, then compare it
	task wst(input logic [4:0] s);
		int n;
		n = 0;
		while (state_ff !== s && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		chk({3'h0, state_ff}, {3'h0, s});
	endtask
	task t_temp;
		temp_switch_closed <= 1'h0;
		repeat (8) @(negedge mclk);
		chk(err_code_ff, 8'h01);
		temp_switch_closed <= 1'h1;
		repeat (8) @(negedge mclk);
		chk(err_code_ff, 8'h00);
		id_in <= 6'h2A;
		id_wr <= 1'h1;
		@(negedge mclk) id_wr <= 1'h0;
		@(negedge mclk);
		chk({2'h0, node_id_ff}, 8'h2A);
		$display("test temp/id done");
	endtask
	task t_seam;
		seam_mode <= 8'h01;
		want <= 3'h1;
		wst(5'h04);
		chk({7'h0, fire_ff}, 8'h01);
		chk({2'h0, sched_ff}, 8'h05);
		wst(5'h08);
		chk({7'h0, fire_ff}, 8'h00);
		want <= 3'h5;
		wst(5'h04);
		repeat (8) @(negedge mclk);
		chk({2'h0, sched_ff}, 8'h14);
		want <= 3'h0;
		repeat (8) @(negedge mclk);
		chk({3'h0, state_ff}, 8'h10);
		wst(5'h01);
		want <= 3'h1;
		wst(5'h08);
		want <= 3'h0;
		repeat (8) @(negedge mclk);
		chk({3'h0, state_ff}, 8'h08);
		wst(5'h10);
		wst(5'h01);
		$display("test seam done");
	endtask
	task t_cont;
		cool_cyc <= 8'h00;
		want <= 3'h1;
		wst(5'h04);
		repeat (200) @(negedge mclk);
		chk({7'h0, fire_ff}, 8'h01);
		want <= 3'h0;
		wst(5'h01);
		seam_mode <= 8'h00;
		want <= 3'h1;
		wst(5'h04);
		chk({7'h0, spot_req_ff}, 8'h01);
		wst(5'h10);
		want <= 3'h0;
		wst(5'h01);
		$display("test continuous/spot done");
	endtask
	task t_modes;
		seam_mode <= 8'h02;
		want <= 3'h1;
		wst(5'h04);
		chk({1'h0, pct_ff}, 8'h32);
		btn_tens <= 1'h1;
		repeat (8) @(negedge mclk);
		btn_tens <= 1'h0;
		repeat (8) @(negedge mclk);
		chk({1'h0, pct_ff}, 8'h33);
		btn_units <= 1'h1;
		repeat (8) @(negedge mclk);
		btn_units <= 1'h0;
		repeat (8) @(negedge mclk);
		chk({1'h0, pct_ff}, 8'h32);
		want <= 3'h0;
		wst(5'h01);
		seam_mode <= 8'h14;
		want <= 3'h1;
		wst(5'h04);
		chk({7'h0, regulate_ff}, 8'h00);
		repeat (40) @(negedge mclk);
		chk({7'h0, regulate_ff}, 8'h01);
		want <= 3'h0;
		wst(5'h01);
		seam_mode <= 8'h03;
		pre_chain_en <= 1'h1;
		want <= 3'h1;
		wst(5'h02);
		repeat (80) @(negedge mclk);
		chk({3'h0, state_ff}, 8'h02);
		wst(5'h04);
		chk({7'h0, spot_req_ff}, 8'h00);
		want <= 3'h3;
		repeat (8) @(negedge mclk);
		chk({7'h0, spot_req_ff}, 8'h01);
		chk({2'h0, sched_ff}, 8'h0A);
		chk({3'h0, state_ff}, 8'h02);
		wst(5'h10);
		want <= 3'h0;
		wst(5'h01);
		$display("test modes done");
	endtask
	task summarize;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		{sys_rst, temp_switch_closed} = 2'h3;
		{id_wr, want, tcnt, line_zero_cross, id_in, btn_tens, btn_units, pre_chain_en} = 0;
		{seam_mode, heat_cyc, cool_cyc} = {8'h00, 8'h02, 8'h03};
		repeat (12) @(negedge mclk);
		sys_rst <= 1'h0;
		repeat (6) @(negedge mclk);
		t_temp;
		t_seam;
		t_cont;
		t_modes;
		summarize;
	end
	// watchdog against a hung wait
	initial begin
		repeat (40000) @(posedge mclk);
		errors++;
		summarize;
	end
endmodule
